// File: inc/flash_regs.vh
/*
 * register offsets and field positions for the torch, fault flag and
 * identity/soft-reset registers, and the torch reset value.
 * assumes nothing beyond a verilog-2005 preprocessor.
 */
`ifndef FLASH_REGS_VH
`define FLASH_REGS_VH

`define TORCH_OFFSET 8'h04
`define FLAGS_OFFSET 8'h05
`define IDENT_OFFSET 8'h06

`define TORCH_RESET 7'h00
`define TORCH_CODE_MSB 6

`define FLAG_INPUT_MONITOR 6
`define FLAG_SHORT 5
`define FLAG_SCALEBACK 3
`define FLAG_SHUTDOWN 2
`define FLAG_UNDERVOLTAGE 1
`define FLAG_TIMEOUT 0
`define FLAG_LIVE_MASK 8'h6f

`define IDENT_SOFT_RESET 7
`define IDENT_TX_ENABLE 6
`define IDENT_ID_LSB 3
`define IDENT_TX_FLAG 2

`endif

// File: verif/flash_status_props.sv
/* port assertions of flash_status_regs
   assumes default ident fields */
`timescale 1ns/10ps
module flash_status_props (
    input wire ref_clk, rst_n, reg_write, reg_read, short_trip, thermal_shutdown_trip, tx_mode_active,
    input wire shutdown_standby, soft_reset_pulse, tx_sync_enable,
    input wire [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire [6:0] torch_level_code
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire w4 = reg_write && reg_addr == 8'h04;
    wire r4 = reg_read && reg_addr == 8'h04;
    wire r6 = reg_read && reg_addr == 8'h06;
    wire rd = reg_read && reg_addr == 8'h05;
    wire sr = reg_write && reg_addr == 8'h06 && reg_wdata[7];
    torch_write_a: assert property (w4 |-> ##2 torch_level_code == $past(reg_wdata[6:0], 2))
        else $error("torch");
    torch_read_a: assert property (r4 |=> reg_rdata == torch_level_code) else $error("torch");
    ident_read_a: assert property (r6 |=>
        reg_rdata == {1'b0, tx_sync_enable, 3'h3, $past(tx_mode_active), 2'h2}) else $error("ident");
    flag_rsvd_a: assert property (rd |=> !reg_rdata[7] && !reg_rdata[4]) else $error("flag");
    flag_clear_a: assert property (rd && !short_trip ##1 rd |=> !reg_rdata[5]) else $error("clear");
    standby_set_a: assert property (thermal_shutdown_trip |-> ##[1:2] shutdown_standby)
        else $error("standby");
    standby_hold_a: assert property ($fell(shutdown_standby) |->
        $past(rd) || $past(sr, 2)) else $error("wake");
    soft_reset_a: assert property (sr |-> ##2 soft_reset_pulse && torch_level_code == 0
        && !tx_sync_enable ##1 !soft_reset_pulse) else $error("reset");
    cover property (sr);
    cover property (rd && shutdown_standby);
    cover property (rd ##1 rd);
endmodule // flash_status_props

bind flash_status_regs flash_status_props u_props (.*);

// File: verif/host_model.sv
/* register port host model
   assumes strobes are taken on rising ref_clk */
`timescale 1ns/10ps
module host_model (
    input wire ref_clk,
    output reg [7:0] reg_addr = 8'h00,
    output reg [7:0] reg_wdata = 8'h00,
    output reg reg_write = 1'b0,
    output reg reg_read = 1'b0
);
    // k[0] write, k[1] read; unused data toggles so nothing stale looks valid
    task acc(input [1:0] k, input [7:0] a, d);
    begin
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = k[0] ? d : ~reg_wdata;
        reg_write = k[0];
        reg_read = k[1];
    end
    endtask
endmodule // host_model

// File: verif/testbench.sv
/* self-checking bench of flash_status_regs
   assumes host_model owns the register port */
`timescale 1ns/10ps
module testbench;
    reg ref_clk = 0, rst_n = 0, tx_mode_active = 0, input_monitor_trip = 0, short_trip = 0;
    reg thermal_scaleback_trip = 0, thermal_shutdown_trip = 0, undervoltage_trip = 0, timeout_trip = 0;
    reg [31:0] seed = 32'ha75df065;
    integer n_fail = 0, checks = 0, j;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire [6:0] torch_level_code;
    wire reg_write, reg_read, tx_sync_enable, shutdown_standby, soft_reset_pulse;
    host_model u_host (.*);
    flash_status_regs u_dut (.*);
    function [31:0] xs(input [31:0] x);
    begin
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    end
    endfunction
    task chk(input [7:0] g, e);
    begin
        checks = checks + 1;
        n_fail = n_fail + (g !== e);
        if (g !== e)
            $display("mismatch %0t %h %h", $time, g, e);
    end
    endtask
    task rc(input [7:0] a, e);
    begin
        u_host.acc(2'h2, a, 8'h00);
        u_host.acc(2'h0, 8'hff, 8'h00);
        chk(reg_rdata, e);
    end
    endtask
    task give_verdict;
    begin
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    initial forever #20 ref_clk = ~ref_clk;
    initial
    begin
        repeat (5) @(negedge ref_clk);
        rst_n = 1;
        rc(8'h04, 8'h00);
        rc(8'h07, 8'h00);
        for (j = 0; j < 8; j = j + 1)
        begin
            seed = xs(seed);
            tx_mode_active = seed[9];
            u_host.acc(2'h1, 8'h04, j ? seed[7:0] : 8'hff);
            rc(8'h04, j ? seed[6:0] : 8'h7f);
            rc(8'h06, {5'h03, tx_mode_active, 2'h2});
        end
        for (j = 0; j < 6; j = j + 1)
        begin
            {input_monitor_trip, short_trip, thermal_scaleback_trip, thermal_shutdown_trip, undervoltage_trip,
                timeout_trip} = 6'h01 << j;
            u_host.acc(2'h2, 8'h05, 8'h00);
            {short_trip, thermal_shutdown_trip, timeout_trip, undervoltage_trip} = 4'h0;
            {input_monitor_trip, thermal_scaleback_trip} = 2'h0;
            u_host.acc(2'h2, 8'h05, 8'h00);
            chk(reg_rdata, 8'h01 << (j > 3 ? j + 1 : j));
            u_host.acc(2'h0, 8'hff, 8'h00);
            chk(reg_rdata, 8'h00);
        end
        u_host.acc(2'h1, 8'h06, 8'h40);
        rc(8'h06, {5'h0b, tx_mode_active, 2'h2});
        u_host.acc(2'h1, 8'h06, 8'h80);
        u_host.acc(2'h0, 8'hff, 8'h00);
        rc(8'h06, {5'h03, tx_mode_active, 2'h2});
        rc(8'h04, 8'h00);
        give_verdict;
    end
endmodule // testbench

// File: verilog/flash_status_regs.v
/*
 * torch brightness, fault flag and identity/soft-reset registers of the
 * flash driver, reached through a byte-wide register port that the serial
 * slave drives (one-cycle write and read strobes, address, data).
 * assumes the serial slave and the analog circuits sit outside, all
 * inputs synchronous to ref_clk; fault inputs are one-cycle or level trips.
 */
//
// Contract
// - torch code is bits 6:0; bit 7 reserved, reads zero.
// - torch code resets to zero, the 2.4 mA step.
// - torch code maps monotonically onto current; code passed straight out.
// - flag bits: 6 monitor, 5 short, 3 scaleback, 2 shutdown, 1 uvlo, 0 timeout.
// - writing one to identity bit 7 resets the whole device.
// - identity bit 6 enables transmit sync; bit 2 shows transmit mode.
// - identity bits 5:3 fixed device id, bits 1:0 revision.
// - reading flags clears them; shutdown holds standby until flags read.
`timescale 1ns/10ps
`include "flash_regs.vh"

module flash_status_regs #(
    parameter [2:0] DEVICE_ID = 3'h3, // arbitrary value
    parameter [1:0] REVISION = 2'h2 // arbitrary value
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // register port from the serial slave
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    // trips from the protection circuits, and transmit mode status
    input wire input_monitor_trip,
    input wire short_trip,
    input wire thermal_scaleback_trip,
    input wire thermal_shutdown_trip,
    input wire undervoltage_trip,
    input wire timeout_trip,
    input wire tx_mode_active,
    // to the current source and core
    output reg [6:0] torch_level_code,
    output reg tx_sync_enable,
    output reg shutdown_standby,
    output reg soft_reset_pulse
);

    reg [6:0] torch_reg;
    reg [7:0] flags_reg;
    reg tx_en_reg;
    reg soft_reset_reg;
    reg [7:0] flags_next;
    reg [7:0] rdata_next;
    wire [7:0] trips;
    wire flags_read;
    wire soft_reset_write;

    assign trips = {1'b0, input_monitor_trip, short_trip, 1'b0, thermal_scaleback_trip,
                    thermal_shutdown_trip, undervoltage_trip, timeout_trip} & `FLAG_LIVE_MASK;
    assign flags_read = reg_read && (reg_addr == `FLAGS_OFFSET);
    assign soft_reset_write = reg_write && (reg_addr == `IDENT_OFFSET) && reg_wdata[`IDENT_SOFT_RESET];

    // a trip in the same cycle as the clearing read survives
    always @*
    begin
        flags_next = flags_reg;
        if (flags_read)
            flags_next = 8'h00;
        flags_next = flags_next | trips;
    end

    always @*
    begin
        case (reg_addr)
            `TORCH_OFFSET: rdata_next = {1'b0, torch_reg};
            `FLAGS_OFFSET: rdata_next = flags_reg;
            `IDENT_OFFSET: rdata_next = {1'b0, tx_en_reg, DEVICE_ID, tx_mode_active, REVISION};
            default: rdata_next = 8'h00;
        endcase
    end

    // soft reset takes a cycle to land so the write itself completes first
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            torch_reg <= `TORCH_RESET;
            flags_reg <= 8'h00;
            tx_en_reg <= 1'b0;
            soft_reset_reg <= 1'b0;
            reg_rdata <= 8'h00;
        end
        else if (soft_reset_reg)
        begin
            torch_reg <= `TORCH_RESET;
            flags_reg <= 8'h00;
            tx_en_reg <= 1'b0;
            soft_reset_reg <= 1'b0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            soft_reset_reg <= soft_reset_write;
            flags_reg <= flags_next;
            if (reg_read)
                reg_rdata <= rdata_next;
            if (reg_write && reg_addr == `TORCH_OFFSET)
                torch_reg <= reg_wdata[`TORCH_CODE_MSB:0];
            if (reg_write && reg_addr == `IDENT_OFFSET)
                tx_en_reg <= reg_wdata[`IDENT_TX_ENABLE];
        end
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            torch_level_code <= `TORCH_RESET;
            tx_sync_enable <= 1'b0;
            shutdown_standby <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end
        else
        begin
            torch_level_code <= soft_reset_reg ? `TORCH_RESET : torch_reg;
            tx_sync_enable <= soft_reset_reg ? 1'b0 : tx_en_reg;
            shutdown_standby <= soft_reset_reg ? 1'b0 : flags_next[`FLAG_SHUTDOWN];
            soft_reset_pulse <= soft_reset_reg;
        end
    end

endmodule // flash_status_regs
